// File: src/pac_access_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - confirmed basic-menu edit stores that parameter to nv memory
// - advanced-menu edits are not stored until an explicit save command
// - code 1001 arms a save of all parameters for next reset
// - reset request: button, reset input toggle or serial write of 100
// - codes 1233/1244 arm 50/60 Hz default load plus save at reset
// - default restore leaves security level and security code untouched
// - level 0 shows basic menu editable; level 1 shows all editable
// - level 2 basic menu read-only; level 3 all menus read-only
// - levels 4 and 5 keep keypad in status mode, no view or edit
// - reset state is basic-menu level with security open
// - level settable via either alias, from keypad even when code set
// - an active locked security code blocks every parameter write except keypad level writes
// - code accepts 0 to 2147483647; nonzero code activates at next reset
// - activation returns display home, shows lock, code reads back zero
// - locked edit prompts for code; match edits, mismatch errors to view
// - after unlock, writing zero to code disables security permanently
// - code 12000 shows only non-default parameters at once; 0 cancels
// - code 12001 shows only destination parameters at once; 0 cancels
// - visibility filters combine with access level hiding
module pac_access_ctrl
  import pac_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // parameter writes from keypad, comms or option modules
  input wire logic wr_valid,
  input wire pac_wr_t wr_req,
  // parameter reads
  input wire logic rd_valid,
  input wire pac_src_t rd_src,
  input wire logic [2:0] rd_id,
  // visibility query for a browsed parameter
  input wire logic qry_valid,
  input wire pac_src_t qry_src,
  input wire pac_attr_t qry_attr,
  // keypad edit flow
  input wire logic edit_req,
  input wire pac_attr_t edit_attr,
  input wire logic code_valid,
  input wire logic [31:0] code_value,
  input wire logic edit_confirm,
  input wire logic edit_cancel,
  // reset request sources
  input wire logic reset_button,
  input wire logic reset_din,
  // write and read answers
  output logic wr_ack_q,
  output logic wr_err_q,
  output logic rd_ok_q,
  output logic rd_err_q,
  output logic [31:0] rd_data_q,
  // query answer
  output logic qry_done_q,
  output logic qry_visible_q,
  output logic qry_editable_q,
  // keypad state
  output logic prompt_code_q,
  output logic edit_mode_q,
  output logic edit_grant_q,
  output logic code_error_q,
  output logic status_only_q,
  output logic lock_icon_q,
  output logic display_home_q,
  // non-volatile memory and defaults
  output logic nv_store_param_q,
  output logic nv_save_all_q,
  output logic load_defaults_q,
  output logic defaults_60hz_q,
  output logic reset_event_q
);

  // ---------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------
  logic [15:0] cmd_q;
  logic [7:0] level_q;
  logic [31:0] code_q;
  logic [31:0] active_code_q;
  logic unlocked_q;
  logic filt_nondef_q;
  logic filt_dest_q;
  logic save_pend_q;
  logic def50_pend_q;
  logic def60_pend_q;
  logic din_prev_q;
  logic din_seen_q;
  pac_state_t state_q;
  pac_state_t state_d;
  logic edit_basic_q;

  // ---------------------------------------------------------------------
  // access decisions
  // ---------------------------------------------------------------------
  logic locked;
  logic level_ro;
  logic level_all;
  logic level_status;
  logic level_noacc;
  logic wr_is_level;
  logic wr_is_keypad;
  logic wr_src_ok;
  logic wr_lock_ok;
  logic wr_val_ok;
  logic wr_ok;
  logic reset_req_wr;
  logic reset_evt;
  logic edit_allowed;

  assign locked = (active_code_q != PAC_CODE_RESET) && !unlocked_q;
  assign level_all = (level_q == PAC_LVL_ALL) || (level_q == PAC_LVL_RO_ALL);
  assign level_ro = (level_q == PAC_LVL_RO_MENU0) ||
                    (level_q == PAC_LVL_RO_ALL);
  assign level_status = (level_q == PAC_LVL_STATUS) ||
                        (level_q == PAC_LVL_NOACCESS);
  assign level_noacc = (level_q == PAC_LVL_NOACCESS);

  assign wr_is_level = (wr_req.id == PAC_ID_LEVEL) ||
                       (wr_req.id == PAC_ID_LEVEL_ALIAS);
  assign wr_is_keypad = (wr_req.src == PAC_SRC_KEYPAD);

  // level 5 shuts out non-keypad sources; keypad level writes pass
  always_comb begin
    if (wr_is_keypad) begin
      wr_src_ok = wr_is_level || (!level_status && !level_ro);
    end else begin
      wr_src_ok = !level_noacc && (wr_is_level || !level_ro);
    end
  end

  // the level stays changeable from the keypad while a code is active
  assign wr_lock_ok = !locked || (wr_is_keypad && wr_is_level);

  // range checks per parameter
  always_comb begin
    unique case (wr_req.id)
      PAC_ID_COMMAND_ENTRY: wr_val_ok = (wr_req.data[31:16] == 16'h0000);
      PAC_ID_LEVEL, PAC_ID_LEVEL_ALIAS: wr_val_ok =
        (wr_req.data <= {24'h00_0000, PAC_LVL_NOACCESS});
      PAC_ID_UNLOCK_CODE: wr_val_ok = (wr_req.data <= PAC_CODE_MAX);
      PAC_ID_RESET_REQ: wr_val_ok = 1'b1;
      default: wr_val_ok = 1'b0;
    endcase
  end

  assign wr_ok = wr_valid && wr_src_ok && wr_lock_ok && wr_val_ok;
  assign reset_req_wr = wr_ok && (wr_req.id == PAC_ID_RESET_REQ) &&
                        (wr_req.data == PAC_RESET_REQ_VALUE);

  // any of the three sources counts as one drive reset request
  assign reset_evt = reset_button || reset_req_wr ||
                     (din_seen_q && (reset_din != din_prev_q));

  // a keypad edit needs a visible, writable parameter at an editable level
  assign edit_allowed = !level_status && !level_ro && edit_attr.writable &&
                        (edit_attr.basic || level_all) &&
                        (!filt_nondef_q || edit_attr.nondefault) &&
                        (!filt_dest_q || edit_attr.destination);

  // ---------------------------------------------------------------------
  // reset input edge detector
  // ---------------------------------------------------------------------
  // first sample only primes, so a high input at reset is no toggle
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      din_prev_q <= 1'b0;
      din_seen_q <= 1'b0;
    end else begin
      din_prev_q <= reset_din;
      din_seen_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------
  // command entry, filters and pending reset actions
  // ---------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      cmd_q <= PAC_CMD_RESET;
      filt_nondef_q <= 1'b0;
      filt_dest_q <= 1'b0;
      save_pend_q <= 1'b0;
      def50_pend_q <= 1'b0;
      def60_pend_q <= 1'b0;
    end else if (reset_evt) begin
      // the pending action runs once and the entry falls back to no action
      save_pend_q <= 1'b0;
      def50_pend_q <= 1'b0;
      def60_pend_q <= 1'b0;
      if (save_pend_q || def50_pend_q || def60_pend_q) begin
        cmd_q <= PAC_CMD_NONE;
      end
    end else if (wr_ok && (wr_req.id == PAC_ID_COMMAND_ENTRY)) begin
      cmd_q <= wr_req.data[15:0];
      // a new code replaces whatever was armed before
      save_pend_q <= (wr_req.data[15:0] == PAC_CMD_SAVE);
      def50_pend_q <= (wr_req.data[15:0] == PAC_CMD_DEF50);
      def60_pend_q <= (wr_req.data[15:0] == PAC_CMD_DEF60);
      if (wr_req.data[15:0] == PAC_CMD_NONDEF) begin
        filt_nondef_q <= 1'b1;
      end else if (wr_req.data[15:0] == PAC_CMD_DEST) begin
        filt_dest_q <= 1'b1;
      end else if (wr_req.data[15:0] == PAC_CMD_NONE) begin
        filt_nondef_q <= 1'b0;
        filt_dest_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------
  // security level and code
  // ---------------------------------------------------------------------
  // a default restore never touches these registers
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      level_q <= PAC_LEVEL_RESET;
      code_q <= PAC_CODE_RESET;
      active_code_q <= PAC_CODE_RESET;
      unlocked_q <= 1'b0;
    end else if (reset_evt) begin
      // the stored code takes effect at the reset request; a level or code write in this cycle is dropped
      active_code_q <= code_q;
      unlocked_q <= 1'b0;
    end else begin
      if (wr_ok && wr_is_level) begin
        level_q <= wr_req.data[7:0];
      end
      if (wr_ok && (wr_req.id == PAC_ID_UNLOCK_CODE)) begin
        code_q <= wr_req.data;
        if (wr_req.data == PAC_CODE_RESET) begin
          active_code_q <= PAC_CODE_RESET;
        end
      end
      if ((state_q == PAC_ST_CODE) && code_valid &&
          (code_value == active_code_q)) begin
        unlocked_q <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------
  // keypad edit state machine
  // ---------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      PAC_ST_VIEW: begin
        if (edit_req && edit_allowed) begin
          state_d = locked ? PAC_ST_CODE : PAC_ST_EDIT;
        end
      end
      PAC_ST_CODE: begin
        if (code_valid) begin
          state_d = (code_value == active_code_q) ? PAC_ST_EDIT
                                                  : PAC_ST_VIEW;
        end else if (edit_cancel) begin
          state_d = PAC_ST_VIEW;
        end
      end
      PAC_ST_EDIT: begin
        if (edit_confirm || edit_cancel) begin
          state_d = PAC_ST_VIEW;
        end
      end
      default: state_d = PAC_ST_VIEW;
    endcase
    // a reset request or a move to status-only levels drops the keypad home
    if (reset_evt || level_status) begin
      state_d = PAC_ST_VIEW;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_q <= PAC_ST_VIEW;
      edit_basic_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if ((state_q == PAC_ST_VIEW) && edit_req) begin
        edit_basic_q <= edit_attr.basic;
      end
    end
  end

  // ---------------------------------------------------------------------
  // keypad outputs
  // ---------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      prompt_code_q <= 1'b0;
      edit_mode_q <= 1'b0;
      edit_grant_q <= 1'b0;
      code_error_q <= 1'b0;
      status_only_q <= 1'b0;
      lock_icon_q <= 1'b0;
      display_home_q <= 1'b0;
      nv_store_param_q <= 1'b0;
    end else begin
      prompt_code_q <= (state_d == PAC_ST_CODE);
      edit_mode_q <= (state_d == PAC_ST_EDIT);
      edit_grant_q <= (state_q != PAC_ST_EDIT) &&
                      (state_d == PAC_ST_EDIT);
      code_error_q <= (state_q == PAC_ST_CODE) && code_valid &&
                      (code_value != active_code_q) && !reset_evt;
      status_only_q <= level_status;
      lock_icon_q <= reset_evt ? (code_q != PAC_CODE_RESET)
                               : (active_code_q != PAC_CODE_RESET) &&
                                 !(wr_ok && wr_req.data == PAC_CODE_RESET &&
                                   wr_req.id == PAC_ID_UNLOCK_CODE);
      display_home_q <= reset_evt && (code_q != PAC_CODE_RESET);
      // advanced edits wait for an explicit save command
      nv_store_param_q <= (state_q == PAC_ST_EDIT) && edit_confirm &&
                          edit_basic_q && !reset_evt;
    end
  end

  // ---------------------------------------------------------------------
  // reset-time actions
  // ---------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      nv_save_all_q <= 1'b0;
      load_defaults_q <= 1'b0;
      defaults_60hz_q <= 1'b0;
      reset_event_q <= 1'b0;
    end else begin
      reset_event_q <= reset_evt;
      nv_save_all_q <= reset_evt &&
        (save_pend_q || def50_pend_q || def60_pend_q);
      load_defaults_q <= reset_evt &&
        (def50_pend_q || def60_pend_q);
      if (reset_evt && (def50_pend_q || def60_pend_q)) begin
        defaults_60hz_q <= def60_pend_q;
      end
    end
  end

  // ---------------------------------------------------------------------
  // write answer
  // ---------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      wr_ack_q <= 1'b0;
      wr_err_q <= 1'b0;
    end else begin
      wr_ack_q <= wr_ok;
      wr_err_q <= wr_valid && !wr_ok;
    end
  end

  // ---------------------------------------------------------------------
  // read answer
  // ---------------------------------------------------------------------
  // the keypad cannot browse at status levels; level 5 shuts out the rest
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      rd_ok_q <= 1'b0;
      rd_err_q <= 1'b0;
      rd_data_q <= 32'h0000_0000;
    end else begin
      rd_ok_q <= 1'b0;
      rd_err_q <= 1'b0;
      rd_data_q <= 32'h0000_0000;
      if (rd_valid) begin
        if ((rd_src == PAC_SRC_KEYPAD) ? level_status : level_noacc) begin
          rd_err_q <= 1'b1;
        end else begin
          rd_ok_q <= 1'b1;
          unique case (rd_id)
            PAC_ID_COMMAND_ENTRY: rd_data_q <= {16'h0000, cmd_q};
            PAC_ID_LEVEL, PAC_ID_LEVEL_ALIAS:
              rd_data_q <= {24'h00_0000, level_q};
            // hide an active code until it is disabled
            PAC_ID_UNLOCK_CODE: rd_data_q <=
              (active_code_q != PAC_CODE_RESET) ? PAC_CODE_RESET
                                                : code_q;
            default: rd_data_q <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // ---------------------------------------------------------------------
  // visibility query
  // ---------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      qry_done_q <= 1'b0;
      qry_visible_q <= 1'b0;
      qry_editable_q <= 1'b0;
    end else begin
      qry_done_q <= qry_valid;
      if (qry_src == PAC_SRC_KEYPAD) begin
        // filters only narrow what the access level already shows
        qry_visible_q <= qry_valid && !level_status &&
          (qry_attr.basic || level_all) &&
          (!filt_nondef_q || qry_attr.nondefault) &&
          (!filt_dest_q || qry_attr.destination);
      end else begin
        qry_visible_q <= qry_valid && !level_noacc;
      end
      qry_editable_q <= qry_valid && qry_attr.writable && !locked &&
        !level_ro &&
        ((qry_src == PAC_SRC_KEYPAD) ?
           (!level_status && (qry_attr.basic || level_all) &&
            (!filt_nondef_q || qry_attr.nondefault) &&
            (!filt_dest_q || qry_attr.destination))
         : !level_noacc);
    end
  end

endmodule // pac_access_ctrl

`default_nettype wire

// File: common/pac_pkg.sv
package pac_pkg;

  // ---------------------------------------------------------------------
  // command codes written into command_entry
  // ---------------------------------------------------------------------
  localparam logic [15:0] PAC_CMD_NONE = 16'h0000;
  localparam logic [15:0] PAC_CMD_SAVE = 16'h03E9; // 1001
  localparam logic [15:0] PAC_CMD_DEF50 = 16'h04D1; // 1233
  localparam logic [15:0] PAC_CMD_DEF60 = 16'h04DC; // 1244
  localparam logic [15:0] PAC_CMD_NONDEF = 16'h2EE0; // 12000
  localparam logic [15:0] PAC_CMD_DEST = 16'h2EE1; // 12001

  // value written to the reset request parameter that asks for a reset
  localparam logic [31:0] PAC_RESET_REQ_VALUE = 32'h0000_0064; // 100

  // ---------------------------------------------------------------------
  // parameter selectors on the access port
  // ---------------------------------------------------------------------
  localparam logic [2:0] PAC_ID_COMMAND_ENTRY = 3'h0;
  localparam logic [2:0] PAC_ID_LEVEL = 3'h1;
  localparam logic [2:0] PAC_ID_LEVEL_ALIAS = 3'h2;
  localparam logic [2:0] PAC_ID_UNLOCK_CODE = 3'h3;
  localparam logic [2:0] PAC_ID_RESET_REQ = 3'h4;

  // ---------------------------------------------------------------------
  // security levels and reset values
  // ---------------------------------------------------------------------
  localparam logic [7:0] PAC_LVL_MENU0 = 8'h00;
  localparam logic [7:0] PAC_LVL_ALL = 8'h01;
  localparam logic [7:0] PAC_LVL_RO_MENU0 = 8'h02;
  localparam logic [7:0] PAC_LVL_RO_ALL = 8'h03;
  localparam logic [7:0] PAC_LVL_STATUS = 8'h04;
  localparam logic [7:0] PAC_LVL_NOACCESS = 8'h05;
  localparam logic [7:0] PAC_LEVEL_RESET = 8'h00;
  localparam logic [31:0] PAC_CODE_RESET = 32'h0000_0000;
  localparam logic [31:0] PAC_CODE_MAX = 32'h7FFF_FFFF; // 2147483647
  localparam logic [15:0] PAC_CMD_RESET = 16'h0000;

  // ---------------------------------------------------------------------
  // types
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    PAC_SRC_KEYPAD = 2'h0,
    PAC_SRC_COMMS = 2'h1,
    PAC_SRC_OPTION = 2'h2
  } pac_src_t;

  typedef struct packed {
    pac_src_t src;
    logic [2:0] id;
    logic [31:0] data;
  } pac_wr_t;

  // attributes of the parameter the keypad or a browser is looking at
  typedef struct packed {
    logic basic;
    logic nondefault;
    logic destination;
    logic writable;
  } pac_attr_t;

  typedef enum logic [2:0] {
    PAC_ST_VIEW = 3'b001,
    PAC_ST_CODE = 3'b010,
    PAC_ST_EDIT = 3'b100
  } pac_state_t;

endpackage

// File: tb/pac_access_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// port checks
// ----
module pac_access_ctrl_monitor
  import pac_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // requests
  input wire logic wr_valid,
  input wire logic rd_valid,
  input wire logic [2:0] rd_id,
  input wire logic qry_valid,
  input wire pac_src_t qry_src,
  input wire logic edit_confirm,
  input wire logic reset_button,
  input wire logic reset_din,
  // answers
  input wire logic wr_ack_q,
  input wire logic wr_err_q,
  input wire logic rd_ok_q,
  input wire logic rd_err_q,
  input wire logic [31:0] rd_data_q,
  input wire logic qry_visible_q,
  // keypad and memory
  input wire logic prompt_code_q,
  input wire logic edit_mode_q,
  input wire logic edit_grant_q,
  input wire logic code_error_q,
  input wire logic status_only_q,
  input wire logic lock_icon_q,
  input wire logic nv_store_param_q,
  input wire logic nv_save_all_q,
  input wire logic load_defaults_q,
  input wire logic reset_event_q
);
  // one clock domain for every check
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  chk_wr_answer: assert property (
    wr_valid |=> wr_ack_q != wr_err_q) else $error("bad write answer");
  chk_rd_answer: assert property (
    rd_valid |=> rd_ok_q != rd_err_q) else $error("bad read answer");
  chk_defaults_save: assert property (
    load_defaults_q |-> nv_save_all_q && reset_event_q)
    else $error("default load without save");
  chk_save_on_reset: assert property (
    nv_save_all_q |-> reset_event_q) else $error("save outside reset");
  chk_button_reset: assert property (
    reset_button |=> reset_event_q) else $error("button reset lost");
  chk_din_reset: assert property (
    rst_b && $past(rst_b) && reset_din != $past(reset_din) |=> reset_event_q)
    else $error("reset input toggle lost");
  chk_status_hidden: assert property (
    status_only_q && qry_valid && qry_src == PAC_SRC_KEYPAD |=> !qry_visible_q)
    else $error("parameter visible in status mode");
  chk_code_hidden: assert property (
    lock_icon_q && rd_valid && rd_id == PAC_ID_UNLOCK_CODE |=> rd_data_q == 0)
    else $error("active code readable");
  chk_grant_edit: assert property (
    edit_grant_q |-> edit_mode_q && !prompt_code_q)
    else $error("grant without edit mode");
  chk_error_view: assert property (
    code_error_q |-> !edit_mode_q && !prompt_code_q)
    else $error("wrong code left edit or prompt");
  chk_store_edit: assert property (
    nv_store_param_q |-> $past(edit_confirm) && $past(edit_mode_q))
    else $error("store without confirmed edit");
endmodule // pac_access_ctrl_monitor

bind pac_access_ctrl pac_access_ctrl_monitor mon (.*);
`default_nettype wire

// File: tb/pac_partner.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// keypad and comms master
// ----
module pac_partner
  import pac_pkg::*;
(
  // clock
  input wire logic clock,
  // requests
  output logic wr_valid,
  output pac_wr_t wr_req,
  output logic rd_valid,
  output pac_src_t rd_src,
  output logic [2:0] rd_id,
  // answers
  input wire logic wr_ack_q,
  input wire logic rd_ok_q,
  input wire logic [31:0] rd_data_q
);
  // idle at start; requests stay low until a task drives them
  initial begin
    wr_valid = 1'b0;
    wr_req = '0;
    rd_valid = 1'b0;
    rd_src = PAC_SRC_KEYPAD;
    rd_id = 3'h0;
  end

  // released data inverted: stale words never look fresh
  task automatic wr(input pac_src_t s, input logic [2:0] id,
    input logic [31:0] d, output logic ack);
    @(negedge clock);
    wr_valid = 1'b1;
    wr_req = '{src: s, id: id, data: d};
    @(negedge clock);
    ack = wr_ack_q;
    wr_valid = 1'b0;
    wr_req.data = ~d;
  endtask

  // one read; answer taken one cycle later
  task automatic rd(input pac_src_t s, input logic [2:0] id,
    output logic ok, output logic [31:0] d);
    @(negedge clock);
    rd_valid = 1'b1;
    rd_src = s;
    rd_id = id;
    @(negedge clock);
    ok = rd_ok_q;
    d = rd_data_q;
    rd_valid = 1'b0;
    rd_id = ~id;
  endtask
endmodule // pac_partner
`default_nettype wire

// File: tb/pac_access_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// access controller bench
// ----
module pac_access_ctrl_bench
  import pac_pkg::*;
;
  localparam pac_src_t KP = PAC_SRC_KEYPAD;
  localparam pac_src_t CM = PAC_SRC_COMMS;
  localparam pac_attr_t A_BAS = 4'b1001; // basic, writable
  localparam pac_attr_t A_ADV = 4'b0001;
  localparam pac_attr_t A_ND = 4'b1101;
  logic clock, rst_b, qry_valid, edit_req, code_valid, edit_confirm;
  logic edit_cancel, reset_button, reset_din, ack, ok;
  logic wr_valid, rd_valid, wr_ack_q, wr_err_q, rd_ok_q, rd_err_q;
  pac_wr_t wr_req;
  pac_src_t rd_src, qry_src;
  pac_attr_t qry_attr, edit_attr;
  logic [2:0] rd_id;
  logic [31:0] code_value, rd_data_q, data;
  logic qry_done_q, qry_visible_q, qry_editable_q, prompt_code_q;
  logic edit_mode_q, edit_grant_q, code_error_q, status_only_q, lock_icon_q;
  logic display_home_q, nv_store_param_q, nv_save_all_q, load_defaults_q;
  logic defaults_60hz_q, reset_event_q;
  int mismatches, num_checks, cycles, ev_n, save_n, load_n, home_n;

  pac_access_ctrl dut (
    .clock, .rst_b, .wr_valid, .wr_req, .rd_valid, .rd_src, .rd_id,
    .qry_valid, .qry_src, .qry_attr, .edit_req, .edit_attr, .code_valid,
    .code_value, .edit_confirm, .edit_cancel, .reset_button, .reset_din,
    .wr_ack_q, .wr_err_q, .rd_ok_q, .rd_err_q, .rd_data_q, .qry_done_q,
    .qry_visible_q, .qry_editable_q, .prompt_code_q, .edit_mode_q,
    .edit_grant_q, .code_error_q, .status_only_q, .lock_icon_q,
    .display_home_q, .nv_store_param_q, .nv_save_all_q, .load_defaults_q,
    .defaults_60hz_q, .reset_event_q);
  pac_partner p (.clock, .wr_valid, .wr_req, .rd_valid, .rd_src, .rd_id,
    .wr_ack_q, .rd_ok_q, .rd_data_q);

  // 200 MHz clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // pulse counters span checks over cycles
  always @(posedge clock) begin
    ev_n += int'(reset_event_q);
    save_n += int'(nv_save_all_q);
    load_n += int'(load_defaults_q);
    home_n += int'(display_home_q);
  end
  // run needs under 1000 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // keypad strobe k: 0 edit, 1 code, 2 confirm, 3 reset
  task automatic key(input int k, input logic [31:0] v);
    @(negedge clock);
    edit_req = (k == 0);
    code_valid = (k == 1);
    edit_confirm = (k == 2);
    reset_button = (k == 3);
    code_value = v;
    @(negedge clock);
    {edit_req, code_valid, edit_confirm, reset_button} = 4'h0;
  endtask

  task automatic cmd(input pac_src_t s, input logic [15:0] c);
    p.wr(s, PAC_ID_COMMAND_ENTRY, 32'(c), ack);
  endtask

  task automatic clr();
    {ev_n, save_n, load_n, home_n} = '0;
  endtask

  task automatic press();
    clr();
    key(3, 32'h0);
    @(negedge clock);
  endtask

  // editable judged only where visible
  task automatic qry(input pac_src_t s, input pac_attr_t a,
    input logic v, input logic e);
    logic [2:0] r;
    @(negedge clock);
    qry_valid = 1'b1;
    qry_src = s;
    qry_attr = a;
    @(negedge clock);
    qry_valid = 1'b0;
    r = {qry_done_q, qry_visible_q, qry_editable_q & qry_visible_q};
    chk(32'(r), 32'({1'b1, v, e & v}));
  endtask

  task automatic t_levels();
    p.rd(KP, PAC_ID_LEVEL, ok, data);
    chk(data, 32'(PAC_LEVEL_RESET));
    for (int l = 0; l < 6; l++) begin
      p.wr(KP, l[0] ? PAC_ID_LEVEL_ALIAS : PAC_ID_LEVEL, 32'(l), ack);
      chk(ack, 1'b1);
      qry(KP, A_BAS, l < 4, l < 2);
      chk(status_only_q, l >= 4);
      qry(KP, A_ADV, l == 1 || l == 3, l == 1);
      qry(CM, A_BAS, l != 5, l < 2 || l == 4);
      cmd(CM, PAC_CMD_NONE);
      chk(ack, !(l inside {2, 3, 5}));
      p.rd(CM, PAC_ID_LEVEL, ok, data);
      chk(ok, l != 5);
    end
    p.wr(KP, PAC_ID_LEVEL, 32'(PAC_LVL_MENU0), ack);
  endtask

  task automatic t_save();
    cmd(KP, PAC_CMD_SAVE);
    press();
    chk(ev_n, 1);
    chk({save_n[3:0], load_n[3:0]}, 8'h10);
    p.rd(KP, PAC_ID_COMMAND_ENTRY, ok, data);
    chk(data, 32'h0);
    press();
    chk(save_n, 0);
  endtask

  task automatic t_restore();
    p.wr(KP, PAC_ID_LEVEL, 32'(PAC_LVL_ALL), ack);
    for (int i = 0; i < 2; i++) begin
      cmd(CM, i ? PAC_CMD_DEF60 : PAC_CMD_DEF50);
      clr();
      if (i == 0) begin
        reset_din = ~reset_din;
      end else begin
        p.wr(CM, PAC_ID_RESET_REQ, PAC_RESET_REQ_VALUE, ack);
      end
      repeat (3) @(negedge clock);
      chk({ev_n[3:0], save_n[3:0], load_n[3:0]}, 32'h111);
      chk(defaults_60hz_q, i[0]);
      p.rd(KP, PAC_ID_LEVEL, ok, data);
      chk(data, 32'(PAC_LVL_ALL));
    end
    // advanced edit: no store
    edit_attr = A_ADV;
    key(0, 32'h0);
    chk(edit_mode_q, 1'b1);
    key(2, 32'h0);
    chk(nv_store_param_q, 1'b0);
    p.wr(KP, PAC_ID_LEVEL, 32'(PAC_LVL_MENU0), ack);
  endtask

  task automatic t_filters();
    cmd(KP, PAC_CMD_NONDEF);
    qry(KP, A_BAS, 1'b0, 1'b0);
    qry(KP, A_ND, 1'b1, 1'b1);
    cmd(KP, PAC_CMD_DEST);
    qry(KP, A_ND, 1'b0, 1'b0);
    qry(KP, 4'b1111, 1'b1, 1'b1);
    qry(KP, 4'b0111, 1'b0, 1'b0);
    cmd(KP, PAC_CMD_NONE);
    qry(KP, A_BAS, 1'b1, 1'b1);
  endtask

  task automatic t_security();
    p.wr(KP, PAC_ID_UNLOCK_CODE, 32'h8000_0000, ack);
    chk(ack, 1'b0);
    p.wr(KP, PAC_ID_UNLOCK_CODE, 32'h0000_04D2, ack);
    chk({ack, lock_icon_q}, 2'b10);
    press();
    chk({home_n[3:0], 3'h0, lock_icon_q}, 8'h11);
    p.rd(KP, PAC_ID_UNLOCK_CODE, ok, data);
    chk(data, 32'h0);
    cmd(CM, PAC_CMD_NONE);
    chk(ack, 1'b0);
    p.wr(KP, PAC_ID_LEVEL_ALIAS, 32'(PAC_LVL_MENU0), ack);
    chk(ack, 1'b1);
    edit_attr = A_BAS;
    key(0, 32'h0);
    chk(prompt_code_q, 1'b1);
    key(1, 32'h0000_0063);
    chk({code_error_q, prompt_code_q, edit_mode_q}, 3'b100);
    key(0, 32'h0);
    key(1, 32'h0000_04D2);
    chk({edit_grant_q, edit_mode_q}, 2'b11);
    key(2, 32'h0);
    chk(nv_store_param_q, 1'b1);
    p.wr(KP, PAC_ID_UNLOCK_CODE, 32'h0, ack);
    chk(ack, 1'b1);
    press();
    chk({home_n[3:0], 3'h0, lock_icon_q}, 8'h00);
  endtask

  // main sequence
  initial begin
    rst_b = 1'b0;
    {qry_valid, edit_req, code_valid, edit_confirm} = 4'h0;
    {edit_cancel, reset_button, reset_din} = 3'h0;
    {qry_src, qry_attr, edit_attr, code_value} = '0;
    repeat (16) @(negedge clock);
    rst_b = 1'b1;
    @(negedge clock);
    t_levels();
    t_save();
    t_restore();
    t_filters();
    t_security();
    test_done();
  end
endmodule // pac_access_ctrl_bench
`default_nettype wire
